/* pkg/psc_pkg.sv */
// Constants, register map and state codes for the power-state control block
package psc_pkg;
   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_HZ = 50_000_000;
   localparam int POR_SHORT_MS = 100;
   localparam int POR_LONG_S = 1;
   localparam int DEB_MS = 10;
   localparam int PULSE_MS = 2;
   localparam int POR_SHORT_CYC = (CLK_HZ / 1000) * POR_SHORT_MS;
   localparam int POR_LONG_CYC = CLK_HZ * POR_LONG_S;
   localparam int DEB_CYC = (CLK_HZ / 1000) * DEB_MS;
   localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;
   localparam int CNT_W = 26;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CONV_CTRL = 8'h00;
   localparam logic [7:0] OFS_CORE_CONV = 8'h04;
   localparam logic [7:0] OFS_CHG_CFG = 8'h08;
   localparam logic [7:0] OFS_EVENT = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   // Field positions
   localparam int B_PERMIT = 0;
   localparam int B_SUPPLY_EN = 1;
   localparam int F_VSEL_LO = 0;
   localparam int F_LPSEL_LO = 2;
   localparam int B_CORE_OFF = 4;
   localparam int B_WAIT_PERMIT = 7;
   localparam int B_EV_PB = 0;
   localparam int B_EV_COVER = 1;
   localparam int B_EV_WARM = 2;
   localparam int EV_W = 3;

   // Reset values
   localparam logic [1:0] RST_CONV_CTRL = 2'h2;
   localparam logic [4:0] RST_CORE_CONV = 5'h03;
   localparam logic RST_WAIT_PERMIT = 1'b0;
   localparam logic [2:0] RST_MASK = 3'h0;

   // Debounced input indices and their idle levels
   localparam int DB_PB = 0;
   localparam int DB_WARM = 1;
   localparam int DB_COVER = 2;
   localparam int DB_N = 3;
   localparam logic [2:0] DB_IDLE = 3'h2;

   // Power states, one-hot
   typedef enum logic [3:0] {
      PSC_ST_START = 4'b0001,
      PSC_ST_ON = 4'b0010,
      PSC_ST_LP = 4'b0100,
      PSC_ST_WAIT = 4'b1000
   } psc_state_t;
endpackage

/* core/psc_ctrl.sv */
// Power-state control pins, reset timing and APB register file
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps

module psc_ctrl #(
   parameter int POR_SHORT = psc_pkg::POR_SHORT_CYC, // 100 ms count
   parameter int POR_LONG = psc_pkg::POR_LONG_CYC, // 1 s count
   parameter int DEBOUNCE = psc_pkg::DEB_CYC, // Debounce count
   parameter int PULSE = psc_pkg::PULSE_CYC // Processor reset count
) (
   input wire logic pclk, // Clock, 50 MHz
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic deep_sleep_request, // Sleep request pin
   input wire logic push_button_in, // Button, active high
   input wire logic warm_reset_in_n, // Warm reset, active low
   input wire logic battery_cover_in, // High when cover fitted
   input wire logic reset_delay_select, // Power-on delay select
   input wire logic main_rail_good, // Main rail power good
   input wire logic core_rail_good, // Core rail in regulation
   input wire logic supply_undervoltage, // Supply below lockout
   input wire logic overtemp_warning, // Thermal shutdown close
   input wire logic supply_present, // USB or adapter present
   output logic power_on_reset_out_n, // Global reset, low
   output logic processor_reset_out_n, // Processor reset, low
   output logic power_fail_warning_out_n, // Power fail, low
   output logic main_conv_en, // Main converter enable
   output logic core_conv_en, // Core converter enable
   output logic [1:0] core_vsel, // Core voltage select
   output logic ldo_reduced, // Regulators reduced power
   output logic low_power_mode, // Low power mode active
   output logic wait_mode, // Wait mode active
   output logic event_irq // Masked event output
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam int NS = 8; // Synchroniser width: seven pins and a tied-low bit
   psc_pkg::psc_state_t state;
   psc_pkg::psc_state_t next_state;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] sync1;
   logic [NS-1:0] sync2;
   logic [2:0] db;
   logic [2:0] db_q;
   logic [psc_pkg::CNT_W-1:0] db_cnt [3];
   logic [1:0] conv_ctrl;
   logic [4:0] core_conv;
   logic wait_permit;
   logic [2:0] ev_flags;
   logic [2:0] ev_mask;
   logic [psc_pkg::CNT_W-1:0] por_cnt;
   logic [psc_pkg::CNT_W-1:0] por_lim;
   logic [psc_pkg::CNT_W-1:0] pulse_cnt;
   logic por_done;
   logic pulse_on;
   logic lp_and;
   logic lp_and_q;
   logic lp_rise;
   logic pb_act;
   logic warm_act;
   logic cover_fall;
   logic cover_ok;
   logic pulse_start;
   logic wr_en;
   logic rd_en;
   logic s_req;
   logic s_dly;
   logic s_main;
   logic s_core;
   logic s_uv;
   logic s_ot;
   logic s_sup;

   // Register decode, used only for the pslverr error flag
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == psc_pkg::OFS_CONV_CTRL) ||
               (a == psc_pkg::OFS_CORE_CONV) ||
               (a == psc_pkg::OFS_CHG_CFG) ||
               (a == psc_pkg::OFS_EVENT) ||
               (a == psc_pkg::OFS_MASK) ||
               (a == psc_pkg::OFS_STATUS);
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   assign pin_raw = {supply_present, overtemp_warning,
                     supply_undervoltage, core_rail_good,
                     main_rail_good, reset_delay_select,
                     deep_sleep_request, 1'b0};

   // Two flops per pin; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
      end
   end

   assign s_req = sync2[1];
   assign s_dly = sync2[2];
   assign s_main = sync2[3];
   assign s_core = sync2[4];
   assign s_uv = sync2[5];
   assign s_ot = sync2[6];
   assign s_sup = sync2[7];

   // ****************************************************************
   // Debouncers for button, warm reset and cover
   // ****************************************************************
   logic [2:0] db_s1;
   logic [2:0] db_s2;
   logic [2:0] db_raw;
   assign db_raw = {battery_cover_in, warm_reset_in_n, push_button_in};

   // Synchronise before debouncing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         db_s1 <= psc_pkg::DB_IDLE;
         db_s2 <= psc_pkg::DB_IDLE;
      end else begin
         db_s1 <= db_raw;
         db_s2 <= db_s1;
      end
   end

   // Level only accepted after staying stable a full interval
   for (genvar i = 0; i < psc_pkg::DB_N; i++) begin : g_db
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            db_cnt[i] <= '0;
            db[i] <= psc_pkg::DB_IDLE[i];
         end else if (db_s2[i] == db[i]) begin
            db_cnt[i] <= '0;
         end else if (db_cnt[i] ==
                      psc_pkg::CNT_W'(DEBOUNCE - 1)) begin
            db_cnt[i] <= '0;
            db[i] <= db_s2[i];
         end else begin
            db_cnt[i] <= db_cnt[i] + 1'b1;
         end
      end
   end

   // Previous debounced levels for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         db_q <= psc_pkg::DB_IDLE;
      end else begin
         db_q <= db;
      end
   end

   // Button active high, warm reset active low
   assign pb_act = db[psc_pkg::DB_PB] & ~db_q[psc_pkg::DB_PB];
   assign warm_act = ~db[psc_pkg::DB_WARM] &
                     db_q[psc_pkg::DB_WARM];
   assign cover_fall = ~db[psc_pkg::DB_COVER] &
                       db_q[psc_pkg::DB_COVER];
   assign cover_ok = db[psc_pkg::DB_COVER];

   // ****************************************************************
   // Power-on reset and processor reset timers
   // ****************************************************************
   assign por_lim = s_dly ? psc_pkg::CNT_W'(POR_LONG - 1)
                          : psc_pkg::CNT_W'(POR_SHORT - 1);

   // Restarts whenever the main rail drops out of its window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt <= '0;
         por_done <= 1'b0;
      end else if (!s_main || !cover_ok) begin
         por_cnt <= '0;
         por_done <= 1'b0;
      end else if (!por_done) begin
         if (por_cnt >= por_lim) begin
            por_done <= 1'b1;
         end else begin
            por_cnt <= por_cnt + 1'b1;
         end
      end
   end

   // Pulse only when the core rail can accept a reset
   assign pulse_start = warm_act & s_core & por_done;

   // Fixed length; a new activation restarts the pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_cnt <= '0;
         pulse_on <= 1'b0;
      end else if (pulse_start) begin
         pulse_cnt <= '0;
         pulse_on <= 1'b1;
      end else if (pulse_on) begin
         if (pulse_cnt == psc_pkg::CNT_W'(PULSE - 1)) begin
            pulse_on <= 1'b0;
         end else begin
            pulse_cnt <= pulse_cnt + 1'b1;
         end
      end
   end

   // ****************************************************************
   // Power state machine
   // ****************************************************************
   // Request is gated by the permit bit before any edge is seen
   assign lp_and = s_req & conv_ctrl[psc_pkg::B_PERMIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lp_and_q <= 1'b0;
      end else begin
         lp_and_q <= lp_and;
      end
   end

   // A held request re-enters only via a permit toggle; else processor must retoggle
   assign lp_rise = lp_and & ~lp_and_q;

   always_comb begin
      next_state = state;
      case (state)
         psc_pkg::PSC_ST_START: begin
            if (por_done) begin
               next_state = psc_pkg::PSC_ST_ON;
            end
         end
         psc_pkg::PSC_ST_ON: begin
            if (!por_done) begin
               next_state = psc_pkg::PSC_ST_START;
            end else if (lp_rise &&
                         !conv_ctrl[psc_pkg::B_SUPPLY_EN]) begin
               // Supply present blocks wait unless permitted
               if (!s_sup || wait_permit) begin
                  next_state = psc_pkg::PSC_ST_WAIT;
               end
            end else if (lp_rise && !pb_act && !warm_act) begin
               next_state = psc_pkg::PSC_ST_LP;
            end
         end
         psc_pkg::PSC_ST_LP: begin
            if (!por_done) begin
               next_state = psc_pkg::PSC_ST_START;
            end else if (!lp_and || pb_act || warm_act ||
                         pulse_start) begin
               next_state = psc_pkg::PSC_ST_ON;
            end
         end
         psc_pkg::PSC_ST_WAIT: begin
            if (pb_act || warm_act) begin
               next_state = psc_pkg::PSC_ST_START;
            end else if (s_sup && !wait_permit) begin
               next_state = psc_pkg::PSC_ST_START;
            end
         end
         default: begin
            next_state = psc_pkg::PSC_ST_START;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= psc_pkg::PSC_ST_START;
      end else if (!cover_ok) begin
         state <= psc_pkg::PSC_ST_START;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Rail controls and output pins
   // ****************************************************************
   // Outputs registered so pins never glitch on decode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_conv_en <= 1'b0;
         core_conv_en <= 1'b0;
         core_vsel <= '0;
         ldo_reduced <= 1'b1;
         low_power_mode <= 1'b0;
         wait_mode <= 1'b0;
      end else begin
         main_conv_en <= cover_ok &&
                         state != psc_pkg::PSC_ST_WAIT;
         core_conv_en <= cover_ok &&
                         state != psc_pkg::PSC_ST_WAIT &&
                         !(state == psc_pkg::PSC_ST_LP &&
                           core_conv[psc_pkg::B_CORE_OFF]);
         // Normal setting untouched in sleep, so exit restores it
         core_vsel <= (state == psc_pkg::PSC_ST_LP)
                      ? core_conv[psc_pkg::F_LPSEL_LO +: 2]
                      : core_conv[psc_pkg::F_VSEL_LO +: 2];
         ldo_reduced <= !cover_ok ||
                        state == psc_pkg::PSC_ST_LP;
         low_power_mode <= state == psc_pkg::PSC_ST_LP;
         wait_mode <= state == psc_pkg::PSC_ST_WAIT;
      end
   end

   // Reset and warning pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_on_reset_out_n <= 1'b0;
         processor_reset_out_n <= 1'b0;
         power_fail_warning_out_n <= 1'b0;
      end else begin
         power_on_reset_out_n <= por_done;
         processor_reset_out_n <= por_done && !pulse_on
                                  && !pulse_start;
         power_fail_warning_out_n <= !(s_uv || s_ot || !cover_ok ||
                                       !por_done);
      end
   end

   // ****************************************************************
   // APB register file
   // ****************************************************************
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   assign pslverr = psel & penable & ~mapped(paddr);

   // Control registers; warm reset leaves them alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_ctrl <= psc_pkg::RST_CONV_CTRL;
         core_conv <= psc_pkg::RST_CORE_CONV;
         wait_permit <= psc_pkg::RST_WAIT_PERMIT;
         ev_mask <= psc_pkg::RST_MASK;
      end else if (wr_en) begin
         case (paddr)
            psc_pkg::OFS_CONV_CTRL: conv_ctrl <= pwdata[1:0];
            psc_pkg::OFS_CORE_CONV: core_conv <= pwdata[4:0];
            psc_pkg::OFS_CHG_CFG: begin
               wait_permit <= pwdata[psc_pkg::B_WAIT_PERMIT];
            end
            psc_pkg::OFS_MASK: ev_mask <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // Sticky events, write one to clear; a new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_flags <= '0;
      end else begin
         for (int k = 0; k < psc_pkg::EV_W; k++) begin
            if (wr_en && paddr == psc_pkg::OFS_EVENT && pwdata[k]) begin
               ev_flags[k] <= 1'b0;
            end
         end
         if (pb_act) ev_flags[psc_pkg::B_EV_PB] <= 1'b1;
         if (warm_act) ev_flags[psc_pkg::B_EV_WARM] <= 1'b1;
         if (cover_fall) ev_flags[psc_pkg::B_EV_COVER] <= 1'b1;
      end
   end

   // Masked event output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_irq <= 1'b0;
      end else begin
         event_irq <= |(ev_flags & ev_mask);
      end
   end

   // Read data captured in setup, held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_en) begin
         case (paddr)
            psc_pkg::OFS_CONV_CTRL: prdata <= {30'h0, conv_ctrl};
            psc_pkg::OFS_CORE_CONV: prdata <= {27'h0, core_conv};
            psc_pkg::OFS_CHG_CFG: prdata <= {24'h0, wait_permit, 7'h0};
            psc_pkg::OFS_EVENT: prdata <= {29'h0, ev_flags};
            psc_pkg::OFS_MASK: prdata <= {29'h0, ev_mask};
            psc_pkg::OFS_STATUS: begin
               prdata <= {23'h0, pulse_on, por_done, db, state};
            end
            default: prdata <= '0;
         endcase
      end
   end
endmodule // psc_ctrl

/* tb/psc_rail_model.sv */
// Converter rail model: enables in, power-good levels out
`timescale 1ns/1ps
module psc_rail_model #(
   parameter int RAMP = 6 // Cycles from enable to power good
) (
   input wire logic pclk, // Clock
   input wire logic main_conv_en, // Main converter enable
   input wire logic core_conv_en, // Core converter enable
   output logic main_rail_good, // Main rail settled
   output logic core_rail_good // Core rail in regulation
);
   // ****************************************************************
   // Rail ramps
   // ****************************************************************
   int main_t = 0, core_t = 0;
   // Slow ramp up, instant collapse, so resets see a real delay
   always @(posedge pclk) begin
      main_t <= (main_conv_en === 1'h1) ? main_t + (main_t < RAMP) : 0;
      core_t <= (core_conv_en === 1'h1) ? core_t + (core_t < RAMP) : 0;
   end
   assign main_rail_good = (main_t >= RAMP);
   assign core_rail_good = (core_t >= RAMP);
endmodule // psc_rail_model

/* tb/psc_ctrl_chk.sv */
// Port checker for the power-state control block
`timescale 1ns/1ps
module psc_ctrl_chk #(
   parameter int DEBOUNCE = 4, // Debounce count
   parameter int PULSE = 10 // Processor reset count
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic deep_sleep_request, // Sleep request pin
   input wire logic battery_cover_in, // Cover pin
   input wire logic supply_undervoltage, // Supply low
   input wire logic power_on_reset_out_n, // Global reset
   input wire logic processor_reset_out_n, // Processor reset
   input wire logic power_fail_warning_out_n, // Power fail
   input wire logic main_conv_en, // Main enable
   input wire logic core_conv_en, // Core enable
   input wire logic ldo_reduced, // Regulators reduced
   input wire logic low_power_mode, // Low power state
   input wire logic wait_mode // Wait state
);
   // ****************************************************************
   // Run-length counters
   // ****************************************************************
   int cov_lo;
   int rst_lo;
   // Pulse length counted only outside global reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cov_lo <= 0;
         rst_lo <= 0;
      end else begin
         cov_lo <= battery_cover_in ? 0 : cov_lo + 1;
         rst_lo <= (!power_on_reset_out_n || processor_reset_out_n) ?
                   0 : rst_lo + 1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_proc_por;
      (!power_on_reset_out_n) [*3] |-> !processor_reset_out_n;
   endproperty
   property p_pf_por;
      (!power_on_reset_out_n) [*3] |-> !power_fail_warning_out_n;
   endproperty
   property p_pf_uv;
      supply_undervoltage [*4] |-> !power_fail_warning_out_n;
   endproperty
   property p_lp_req;
      $rose(low_power_mode) |-> $past(deep_sleep_request, 2);
   endproperty
   property p_lp_exit;
      (!deep_sleep_request) [*6] |-> !low_power_mode;
   endproperty
   property p_wait_off;
      wait_mode [*2] |-> !main_conv_en && !core_conv_en;
   endproperty
   property p_cover;
      cov_lo > DEBOUNCE + 6 |-> !main_conv_en && !core_conv_en && ldo_reduced;
   endproperty
   property p_cover_pf;
      cov_lo > DEBOUNCE + 6 |-> !power_fail_warning_out_n;
   endproperty
   property p_pulse_len;
      $rose(processor_reset_out_n) && rst_lo > 2 |->
         rst_lo >= PULSE - 1 && rst_lo <= PULSE + 2;
   endproperty
   property p_pulse_lp;
      $fell(processor_reset_out_n) |-> ##[0:3] !low_power_mode;
   endproperty
   a_proc_por: assert property (p_proc_por)
      else $error("processor reset up in global reset");
   a_pf_por: assert property (p_pf_por)
      else $error("power fail up in global reset");
   a_pf_uv: assert property (p_pf_uv)
      else $error("power fail missing on undervoltage");
   a_lp_req: assert property (p_lp_req)
      else $error("low power entered without request");
   a_lp_exit: assert property (p_lp_exit)
      else $error("low power after request drop");
   a_wait_off: assert property (p_wait_off)
      else $error("converters on in wait");
   a_cover: assert property (p_cover)
      else $error("converters on with cover removed");
   a_cover_pf: assert property (p_cover_pf)
      else $error("power fail missing with cover removed");
   a_pulse_len: assert property (p_pulse_len)
      else $error("processor reset pulse length wrong");
   a_pulse_lp: assert property (p_pulse_lp)
      else $error("low power kept after processor reset");
   c_lp: cover property ($rose(low_power_mode));
   c_wait: cover property ($rose(wait_mode));
   c_pulse: cover property ($rose(processor_reset_out_n) && rst_lo > 2);
endmodule // psc_ctrl_chk

bind psc_ctrl psc_ctrl_chk #(.DEBOUNCE(DEBOUNCE), .PULSE(PULSE)) u_chk (.*);

/* tb/psc_ctrl_tb.sv */
// Self-checking bench for the power-state control block
`timescale 1ns/1ps
module psc_ctrl_tb;
   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   localparam int DEB = 4;
   logic pclk = 1'h0, presetn = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, main_rail_good, core_rail_good;
   logic deep_sleep_request = 1'h0, push_button_in = 1'h0;
   logic warm_reset_in_n = 1'h1, battery_cover_in = 1'h0;
   logic reset_delay_select = 1'h0, supply_undervoltage = 1'h0;
   logic overtemp_warning = 1'h0, supply_present = 1'h0;
   logic power_on_reset_out_n, processor_reset_out_n;
   logic power_fail_warning_out_n, main_conv_en, core_conv_en;
   logic [1:0] core_vsel;
   logic ldo_reduced, low_power_mode, wait_mode, event_irq;
   int fails = 0, checks_done = 0, wcnt;
   integer seed = 32'h6435;
   logic [31:0] rnd;
   logic [32:0] expq[$];
   always #10 pclk = ~pclk;
   psc_ctrl #(.POR_SHORT(40), .POR_LONG(80), .DEBOUNCE(DEB), .PULSE(10))
      u_dut (.*);
   psc_rail_model u_rail (.*);
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic final_report();
      if (fails == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      checks_done++;
      if (!ok) begin
         fails++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Bounded wait; wcnt keeps cycles spent
   task automatic wait_lvl(ref logic s, input logic v, input int lim);
      wcnt = 0;
      while (s !== v && wcnt < lim) begin
         @(posedge pclk);
         wcnt++;
      end
      if (s !== v) begin
         chk(1'b0, "wait timed out");
         final_report();
      end
   endtask
   // Reads queue expectations
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      int n;
      if (!w) expq.push_back(e);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
      if (n >= 20) begin
         chk(1'b0, "bus timed out");
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d, 33'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      apb(1'h0, a, 32'h0, e);
   endtask
   // Read monitor: oldest expectation vs bus
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'h1 && !pwrite) begin
         checks_done++;
         if ({pslverr, prdata} !== expq.pop_front()) begin
            fails++;
            $display("[FAIL] %0t read mismatch", $time);
         end
      end
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      hold(6);
      presetn <= 1'h1;
      @(posedge pclk);
      chk(power_on_reset_out_n === 1'h0 && processor_reset_out_n === 1'h0
          && power_fail_warning_out_n === 1'h0, "reset outs");
      battery_cover_in <= 1'h1;
      wait_lvl(power_on_reset_out_n, 1'h1, 400);
      chk(wcnt >= 40, "short delay");
      hold(4);
      chk(processor_reset_out_n === 1'h1 && core_vsel === 2'h3, "on");
      rd(psc_pkg::OFS_STATUS, 33'hE2);
      rd(8'h20, {1'h1, 32'h0});
      rnd = $random(seed);
      wr(psc_pkg::OFS_MASK, rnd);
      rd(psc_pkg::OFS_MASK, {30'h0, rnd[2:0]});
      wr(psc_pkg::OFS_MASK, 32'h7);
      wr(psc_pkg::OFS_CORE_CONV, 32'h0D);
      wr(psc_pkg::OFS_CONV_CTRL, 32'h2);
      deep_sleep_request <= 1'h1;
      hold(12);
      chk(low_power_mode === 1'h0, "permit clear");
      wr(psc_pkg::OFS_CONV_CTRL, 32'h3);
      wait_lvl(low_power_mode, 1'h1, 12);
      chk(core_vsel === 2'h3 && main_conv_en === 1'h1, "lp rail");
      wr(psc_pkg::OFS_CONV_CTRL, 32'h2);
      wait_lvl(low_power_mode, 1'h0, 12);
      wr(psc_pkg::OFS_CONV_CTRL, 32'h3);
      wait_lvl(low_power_mode, 1'h1, 12);
      deep_sleep_request <= 1'h0;
      wait_lvl(low_power_mode, 1'h0, 12);
      chk(core_vsel === 2'h1, "vsel back");
      deep_sleep_request <= 1'h1;
      wait_lvl(low_power_mode, 1'h1, 12);
      push_button_in <= 1'h1;
      wait_lvl(low_power_mode, 1'h0, DEB + 12);
      chk(core_vsel === 2'h1, "button restore");
      push_button_in <= 1'h0;
      hold(12);
      chk(low_power_mode === 1'h0 && event_irq === 1'h1, "held");
      rd(psc_pkg::OFS_EVENT, 33'h1);
      wr(psc_pkg::OFS_EVENT, 32'h1);
      hold(2);
      chk(event_irq === 1'h0, "event clear");
      wr(psc_pkg::OFS_CORE_CONV, 32'h1D);
      deep_sleep_request <= 1'h0;
      hold(6);
      deep_sleep_request <= 1'h1;
      wait_lvl(low_power_mode, 1'h1, 12);
      hold(2);
      chk(core_conv_en === 1'h0, "core off");
      wr(psc_pkg::OFS_CORE_CONV, 32'h0D);
      warm_reset_in_n <= 1'h0;
      hold(2);
      warm_reset_in_n <= 1'h1;
      hold(10);
      chk(processor_reset_out_n === 1'h1, "glitch");
      warm_reset_in_n <= 1'h0;
      wait_lvl(processor_reset_out_n, 1'h0, DEB + 12);
      wait_lvl(low_power_mode, 1'h0, 4);
      warm_reset_in_n <= 1'h1;
      wait_lvl(processor_reset_out_n, 1'h1, 30);
      chk(wcnt >= 8, "pulse length");
      rd(psc_pkg::OFS_CORE_CONV, 33'h0D);
      rd(psc_pkg::OFS_EVENT, 33'h4);
      wr(psc_pkg::OFS_EVENT, 32'h7);
      wr(psc_pkg::OFS_CONV_CTRL, 32'h1);
      deep_sleep_request <= 1'h0;
      hold(6);
      deep_sleep_request <= 1'h1;
      wait_lvl(wait_mode, 1'h1, 12);
      push_button_in <= 1'h1;
      wait_lvl(wait_mode, 1'h0, DEB + 12);
      push_button_in <= 1'h0;
      wait_lvl(power_on_reset_out_n, 1'h1, 400);
      hold(12);
      supply_present <= 1'h1;
      wr(psc_pkg::OFS_CHG_CFG, 32'h0);
      wr(psc_pkg::OFS_CONV_CTRL, 32'h1);
      deep_sleep_request <= 1'h0;
      hold(6);
      deep_sleep_request <= 1'h1;
      hold(15);
      chk(wait_mode === 1'h0, "wait refused");
      supply_present <= 1'h0;
      for (int i = 0; i < 2; i++) begin
         {overtemp_warning, supply_undervoltage} <= 2'h1 << i;
         hold(6);
         chk(power_fail_warning_out_n === 1'h0, "fault warn");
         {overtemp_warning, supply_undervoltage} <= 2'h0;
         hold(6);
         chk(power_fail_warning_out_n === 1'h1, "fault end");
      end
      wr(psc_pkg::OFS_EVENT, 32'h7);
      battery_cover_in <= 1'h0;
      hold(DEB + 12);
      chk(main_conv_en === 1'h0 && ldo_reduced === 1'h1, "cover");
      rd(psc_pkg::OFS_EVENT, 33'h2);
      reset_delay_select <= 1'h1;
      battery_cover_in <= 1'h1;
      wait_lvl(power_on_reset_out_n, 1'h1, 400);
      chk(wcnt >= 80, "long delay");
      final_report();
   end
endmodule // psc_ctrl_tb
